// ===== pkg/synth_cfg_pkg.sv
/*
  Constants, types and helpers for the synthesizer and timestamp configuration registers.
  Assumes a 32-bit AXI4-Lite master; each 8-bit register sits in the low byte of one aligned word.
*/
// Contract
// R1 - Software writes zeros into reserved bits of these configuration registers.
// R2 - Timestamp control bit 1 selects low-voltage PECL input mode; resets to zero.
// R3 - Timestamp control bit 0 enables the timestamp receiver; resets to zero.
// R4 - Reference clock drives only when its enable bit and synthesizer enable are set.
// R5 - Reference output enable bit resets to one, so output starts with the synthesizer.
// R6 - First divider bits 3:2 select second divider: 1, 2, 4; code 3 reserved.
// R7 - First divider bits 1:0 select first divider: 5, 4, 3; code 3 reserved.
// R8 - Software holds synthesizer reset while changing any feedback divider field.
// R9 - Second divider bits 5:0 hold third divider ratio 1..63; resets to 32.
// R10 - Divider chain runs first, then second, then third divider to the detector.
// R11 - Bias field resets to 0x4F; software writes 0x4A when using the synthesizer.
// R12 - Every register reads back its last written value and resets to default; the status word at 0x40 ignores writes and reads live status.
package synth_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_STAMP = 7'h3b;
  localparam logic [6:0] IDX_REFOUT = 7'h3c;
  localparam logic [6:0] IDX_DIV_ONE = 7'h3d;
  localparam logic [6:0] IDX_DIV_TWO = 7'h3e;
  localparam logic [6:0] IDX_OSC_BIAS = 7'h3f;
  localparam logic [6:0] IDX_STATUS = 7'h40;
  localparam logic [6:0] IDX_SER_EMPH = 7'h48;

  // Storage slots
  localparam int NUM_REGS = 6;
  localparam logic [2:0] SLOT_STAMP = 3'h0;
  localparam logic [2:0] SLOT_REFOUT = 3'h1;
  localparam logic [2:0] SLOT_DIV_ONE = 3'h2;
  localparam logic [2:0] SLOT_DIV_TWO = 3'h3;
  localparam logic [2:0] SLOT_OSC_BIAS = 3'h4;
  localparam logic [2:0] SLOT_SER_EMPH = 3'h5;

  // Reset values
  localparam logic [7:0] RST_STAMP = 8'h00;
  localparam logic [7:0] RST_REFOUT = 8'h01;
  localparam logic [7:0] RST_DIV_ONE = 8'h00;
  localparam logic [7:0] RST_DIV_TWO = 8'h20;
  localparam logic [7:0] RST_OSC_BIAS = 8'h4f;
  localparam logic [7:0] RST_SER_EMPH = 8'h00;
  localparam logic [7:0] RESET_VALS [NUM_REGS] = '{RST_STAMP, RST_REFOUT, RST_DIV_ONE,
                                                  RST_DIV_TWO, RST_OSC_BIAS, RST_SER_EMPH};

  // Field positions
  localparam int BIT_RECV_ON = 0;
  localparam int BIT_PECL = 1;
  localparam int BIT_REF_ON = 0;
  localparam int FIRST_LSB = 0;
  localparam int SECOND_LSB = 2;
  localparam int THIRD_LSB = 0;
  localparam int THIRD_W = 6;
  localparam int BIAS_W = 7;
  localparam int EMPH_W = 4;
  localparam int TOTAL_W = 11;

  // Divider ratios by code
  localparam logic [2:0] FIRST_RATIO_C0 = 3'h5;
  localparam logic [2:0] FIRST_RATIO_C1 = 3'h4;
  localparam logic [2:0] FIRST_RATIO_C2 = 3'h3;
  localparam logic [2:0] SECOND_RATIO_C0 = 3'h1;
  localparam logic [2:0] SECOND_RATIO_C1 = 3'h2;
  localparam logic [2:0] SECOND_RATIO_C2 = 3'h4;
  localparam logic [2:0] RATIO_RESERVED = 3'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic stamp_input_receiver_on;
    logic stamp_input_pecl_mode;
    logic ref_clock_output;
    logic [2:0] first_ratio;
    logic [2:0] second_ratio;
    logic [THIRD_W-1:0] third_ratio;
    logic [TOTAL_W-1:0] total_ratio;
    logic [BIAS_W-1:0] oscillator_bias_level;
    logic [EMPH_W-1:0] serializer_emphasis_level;
  } synth_cfg_t;

  function automatic logic idx_is_store(input logic [6:0] idx);
    return idx inside {IDX_STAMP, IDX_REFOUT, IDX_DIV_ONE, IDX_DIV_TWO, IDX_OSC_BIAS, IDX_SER_EMPH};
  endfunction

  function automatic logic idx_mapped(input logic [6:0] idx);
    return idx_is_store(idx) || (idx == IDX_STATUS);
  endfunction

  function automatic logic [2:0] idx_slot(input logic [6:0] idx);
    logic [2:0] s;
    s = SLOT_STAMP;
    case (idx)
      IDX_REFOUT: s = SLOT_REFOUT;
      IDX_DIV_ONE: s = SLOT_DIV_ONE;
      IDX_DIV_TWO: s = SLOT_DIV_TWO;
      IDX_OSC_BIAS: s = SLOT_OSC_BIAS;
      IDX_SER_EMPH: s = SLOT_SER_EMPH;
      default: s = SLOT_STAMP;
    endcase
    return s;
  endfunction

endpackage

// ===== hw/axil_write_capture.sv
/*
  AXI4-Lite write channel slave: takes address and data in either order, then issues one write strobe.
  Assumes the reset is already synchronised to clk_sys.
*/
`timescale 1ns/1ps
module axil_write_capture
  import synth_cfg_pkg::*;
#(
  parameter int ADDR_W = 9
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  // AXI write channels
  input wire logic awvalid,
  input wire logic [ADDR_W-1:0] awaddr,
  output logic awready,
  input wire logic wvalid,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic wready,
  output logic bvalid,
  output logic [1:0] bresp,
  input wire logic bready,
  // Write strobe to the register bank
  output logic wr_en,
  output logic [6:0] wr_idx,
  output logic [7:0] wr_data,
  output logic wr_lane0
);

  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;

  assign wr_en = aw_held && w_held && !bvalid;
  assign next_aw_held = wr_en ? 1'b0 : (aw_held || (awvalid && awready));
  assign next_w_held = wr_en ? 1'b0 : (w_held || (wvalid && wready));
  assign next_bvalid = wr_en ? 1'b1 : (bvalid && !bready);

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      bvalid <= next_bvalid;
      awready <= !next_aw_held && !next_bvalid;
      wready <= !next_w_held && !next_bvalid;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wr_idx <= 7'h00;
      wr_data <= 8'h00;
      wr_lane0 <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
        wr_idx <= awaddr[8:2];
      if (wvalid && wready)
      begin
        wr_data <= wdata[7:0];
        wr_lane0 <= wstrb[0];
      end
      if (wr_en)
        bresp <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
  end

endmodule // axil_write_capture

// ===== hw/divider_decode.sv
/*
  Turns the feedback divider fields into ratios and the whole chain ratio.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
module divider_decode
  import synth_cfg_pkg::*;
(
  // Divider fields
  input wire logic [1:0] first_code,
  input wire logic [1:0] second_code,
  input wire logic [THIRD_W-1:0] third_value,
  // Ratios
  output logic [2:0] first_ratio,
  output logic [2:0] second_ratio,
  output logic [TOTAL_W-1:0] total_ratio,
  output logic code_reserved
);

  logic [TOTAL_W-1:0] chain;

  always_comb
  begin
    case (first_code)
      2'h0: first_ratio = FIRST_RATIO_C0; // R7
      2'h1: first_ratio = FIRST_RATIO_C1; // R7
      2'h2: first_ratio = FIRST_RATIO_C2; // R7
      default: first_ratio = RATIO_RESERVED;
    endcase
    case (second_code)
      2'h0: second_ratio = SECOND_RATIO_C0; // R6
      2'h1: second_ratio = SECOND_RATIO_C1; // R6
      2'h2: second_ratio = SECOND_RATIO_C2; // R6
      default: second_ratio = RATIO_RESERVED;
    endcase
  end

  // First feeds second, second feeds third
  assign chain = TOTAL_W'(first_ratio) * TOTAL_W'(second_ratio) * TOTAL_W'(third_value); // R10
  assign total_ratio = chain;
  assign code_reserved = (first_code == 2'h3) || (second_code == 2'h3) || (third_value == 6'h00);

endmodule // divider_decode

// ===== hw/synth_and_stamp_config_regs.sv
/*
  Configuration registers for the clock synthesizer dividers, oscillator bias, reference clock output
  gating, timestamp receiver and serializer emphasis, reached over AXI4-Lite.
  Assumes synth_enable_pin comes from outside the clock domain and that one master drives the bus.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module synth_and_stamp_config_regs
  import synth_cfg_pkg::*;
#(
  parameter int ADDR_W = 9
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // AXI4-Lite write
  input wire logic awvalid,
  input wire logic [ADDR_W-1:0] awaddr,
  output logic awready,
  input wire logic wvalid,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic wready,
  output logic bvalid,
  output logic [1:0] bresp,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic arvalid,
  input wire logic [ADDR_W-1:0] araddr,
  output logic arready,
  output logic rvalid,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rready,
  // Synthesizer enable pin
  input wire logic synth_enable_pin,
  // Configuration to the analog blocks
  output synth_cfg_t synth_cfg
);

  // Register index is taken from address bits 8:2
  if (ADDR_W < 9)
  begin : g_addr_w_check
    $error("ADDR_W must be at least 9");
  end

  // Reset release
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Synthesizer enable synchroniser
  logic synth_en_meta;
  logic synth_en;

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      synth_en_meta <= 1'b0;
      synth_en <= 1'b0;
    end
    else
    begin
      synth_en_meta <= synth_enable_pin;
      synth_en <= synth_en_meta;
    end
  end

  // Write side
  logic wr_en;
  logic [6:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_lane0;

  axil_write_capture #(
    .ADDR_W(ADDR_W)
  ) u_write (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .awvalid(awvalid),
    .awaddr(awaddr),
    .awready(awready),
    .wvalid(wvalid),
    .wdata(wdata),
    .wstrb(wstrb),
    .wready(wready),
    .bvalid(bvalid),
    .bresp(bresp),
    .bready(bready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_lane0(wr_lane0)
  );

  // Register bank; all eight bits stored, reserved ones included
  logic [7:0] bank [NUM_REGS];
  wire store_hit = wr_en && wr_lane0 && idx_is_store(wr_idx);
  wire [2:0] wr_slot = idx_slot(wr_idx);

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        bank[i] <= RESET_VALS[i]; // R5 R12
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (store_hit && (wr_slot == 3'(i)))
          bank[i] <= wr_data; // R12
      end
    end
  end

  // Named fields
  wire [7:0] stamp_reg = bank[SLOT_STAMP];
  wire [7:0] refout_reg = bank[SLOT_REFOUT];
  wire [7:0] div_one_reg = bank[SLOT_DIV_ONE];
  wire [7:0] div_two_reg = bank[SLOT_DIV_TWO];
  wire [7:0] osc_reg = bank[SLOT_OSC_BIAS];
  wire [7:0] emph_reg = bank[SLOT_SER_EMPH];
  wire ref_output_on = refout_reg[BIT_REF_ON];

  // Divider decode
  logic [2:0] first_ratio;
  logic [2:0] second_ratio;
  logic [TOTAL_W-1:0] total_ratio;
  logic code_reserved;

  divider_decode u_decode (
    .first_code(div_one_reg[FIRST_LSB +: 2]),
    .second_code(div_one_reg[SECOND_LSB +: 2]),
    .third_value(div_two_reg[THIRD_LSB +: THIRD_W]),
    .first_ratio(first_ratio),
    .second_ratio(second_ratio),
    .total_ratio(total_ratio),
    .code_reserved(code_reserved)
  );

  // Outputs, each from a flip-flop
  synth_cfg_t next_cfg;

  always_comb
  begin
    next_cfg.stamp_input_receiver_on = stamp_reg[BIT_RECV_ON]; // R3
    next_cfg.stamp_input_pecl_mode = stamp_reg[BIT_PECL]; // R2
    next_cfg.ref_clock_output = ref_output_on && synth_en; // R4
    next_cfg.first_ratio = first_ratio; // R7
    next_cfg.second_ratio = second_ratio; // R6
    next_cfg.third_ratio = div_two_reg[THIRD_LSB +: THIRD_W]; // R9
    next_cfg.total_ratio = total_ratio; // R10
    next_cfg.oscillator_bias_level = osc_reg[BIAS_W-1:0];
    next_cfg.serializer_emphasis_level = emph_reg[EMPH_W-1:0];
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      synth_cfg <= '0;
    else
      synth_cfg <= next_cfg;
  end

  // Status word: bit 0 reference output driven, bit 1 synthesizer enable seen, bit 2 bad divider code
  wire [7:0] status_word = {5'h00, code_reserved, synth_en, synth_cfg.ref_clock_output};

  // Read side
  wire ar_take = arvalid && arready;
  wire [6:0] rd_idx = araddr[8:2];
  wire next_rvalid = ar_take ? 1'b1 : (rvalid && !rready);
  wire [7:0] rd_byte = (rd_idx == IDX_STATUS) ? status_word :
                       idx_is_store(rd_idx) ? bank[idx_slot(rd_idx)] : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else
    begin
      rvalid <= next_rvalid;
      arready <= !next_rvalid;
      if (ar_take)
      begin
        rdata <= {24'h00_0000, rd_byte}; // R12
        rresp <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_sync_n);

  sequence stamp_write;
    store_hit && (wr_idx == IDX_STAMP);
  endsequence

  sequence div_one_write;
    store_hit && (wr_idx == IDX_DIV_ONE);
  endsequence

  AST_STAMP_PECL: assert property ( // R2
    stamp_write ##2 !store_hit |-> synth_cfg.stamp_input_pecl_mode == $past(wr_data[BIT_PECL], 2))
    else $error("pecl mode does not follow write");

  AST_STAMP_RECV: assert property ( // R3
    stamp_write ##2 !store_hit |-> synth_cfg.stamp_input_receiver_on == $past(wr_data[BIT_RECV_ON], 2))
    else $error("receiver enable does not follow write");

  AST_REF_GATE: assert property ( // R4
    synth_cfg.ref_clock_output |-> $past(ref_output_on) && $past(synth_en))
    else $error("reference output driven without both enables");

  AST_REF_ON_RESET: assert property ( // R5
    $rose(rst_sync_n) |-> ref_output_on)
    else $error("reference enable not one after reset");

  AST_SECOND_DIV: assert property ( // R6
    div_one_write ##1 (div_one_reg[SECOND_LSB +: 2] == 2'h2) ##1 (div_one_reg[SECOND_LSB +: 2] == 2'h2)
    |-> synth_cfg.second_ratio == 3'h4)
    else $error("second divider code 2 not divide by four");

  AST_FIRST_DIV: assert property ( // R7
    $past(rst_sync_n) && ($past(div_one_reg[FIRST_LSB +: 2]) == 2'h0) |-> synth_cfg.first_ratio == 3'h5)
    else $error("first divider code 0 not divide by five");

  AST_THIRD_DIV: assert property ( // R9
    $rose(rst_sync_n) ##1 !$past(store_hit) |-> synth_cfg.third_ratio == 6'h20)
    else $error("third divider not 32 after reset");

  AST_CHAIN: assert property ( // R10
    synth_cfg.total_ratio == TOTAL_W'(synth_cfg.first_ratio) * TOTAL_W'(synth_cfg.second_ratio)
                             * TOTAL_W'(synth_cfg.third_ratio))
    else $error("chain ratio not product of three dividers");

  AST_READBACK: assert property ( // R12
    ar_take && (rd_idx == IDX_OSC_BIAS) && !store_hit |=> rvalid && (rdata[7:0] == $past(osc_reg)))
    else $error("bias register read back wrong");

  // Two edges after release the outputs show the reset values
  sequence release_settled;
    $rose(rst_sync_n) ##1 !$past(store_hit);
  endsequence

  AST_STAMP_RESET: assert property ( // R3
    release_settled |-> !synth_cfg.stamp_input_receiver_on && !synth_cfg.stamp_input_pecl_mode)
    else $error("timestamp controls not clear after reset");

  AST_BIAS_RESET: assert property ( // R12
    release_settled |-> synth_cfg.oscillator_bias_level == RST_OSC_BIAS[BIAS_W-1:0])
    else $error("bias level not at default after reset");

  AST_REF_FOLLOW: assert property ( // R4
    $past(rst_sync_n) |-> synth_cfg.ref_clock_output == ($past(ref_output_on) && $past(synth_en)))
    else $error("reference output off although both enables set");

  AST_FIRST_DIV_FOUR: assert property ( // R7
    $past(rst_sync_n) && ($past(div_one_reg[FIRST_LSB +: 2]) == 2'h1) |-> synth_cfg.first_ratio == 3'h4)
    else $error("first divider code 1 not divide by four");

  AST_FIRST_DIV_THREE: assert property ( // R7
    $past(rst_sync_n) && ($past(div_one_reg[FIRST_LSB +: 2]) == 2'h2) |-> synth_cfg.first_ratio == 3'h3)
    else $error("first divider code 2 not divide by three");

  AST_SECOND_DIV_ONE: assert property ( // R6
    $past(rst_sync_n) && ($past(div_one_reg[SECOND_LSB +: 2]) == 2'h0) |-> synth_cfg.second_ratio == 3'h1)
    else $error("second divider code 0 not divide by one");

  AST_SECOND_DIV_TWO: assert property ( // R6
    $past(rst_sync_n) && ($past(div_one_reg[SECOND_LSB +: 2]) == 2'h1) |-> synth_cfg.second_ratio == 3'h2)
    else $error("second divider code 1 not divide by two");

  AST_SECOND_RESERVED: assert property ( // R6
    $past(rst_sync_n) && ($past(div_one_reg[SECOND_LSB +: 2]) == 2'h3) |-> synth_cfg.second_ratio == 3'h0)
    else $error("reserved second divider code gives a ratio");

  AST_THIRD_FOLLOW: assert property ( // R9
    $past(rst_sync_n) |-> synth_cfg.third_ratio == $past(div_two_reg[THIRD_LSB +: THIRD_W]))
    else $error("third divider does not follow its field");

  AST_BIAS_FOLLOW: assert property ( // R12
    $past(rst_sync_n) |-> synth_cfg.oscillator_bias_level == $past(osc_reg[BIAS_W-1:0]))
    else $error("bias level does not follow its field");

  AST_EMPH_FOLLOW: assert property ( // R12
    $past(rst_sync_n) |-> synth_cfg.serializer_emphasis_level == $past(emph_reg[EMPH_W-1:0]))
    else $error("emphasis level does not follow its field");

  AST_DIV_TWO_STORE: assert property ( // R12
    store_hit && (wr_idx == IDX_DIV_TWO) |=> div_two_reg == $past(wr_data))
    else $error("third divider write did not land");

  AST_READ_ANSWER: assert property ( // R12
    ar_take |=> rvalid)
    else $error("read not answered one cycle after address taken");

endmodule // synth_and_stamp_config_regs

// ===== tb/synth_and_stamp_config_regs_tb.sv
/*
  Self-checking bench for the synthesizer and timestamp configuration registers.
  Assumes AXI4-Lite byte address = 4*index and outputs that lag the registers by a few clocks.
*/
`timescale 1ns/1ps
module synth_and_stamp_config_regs_tb;
  import synth_cfg_pkg::*;

  typedef struct {logic rd; logic [1:0] resp; logic [31:0] data;} exp_t;

  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic awvalid = 1'b0;
  logic [8:0] awaddr = 9'h000;
  logic wvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic [8:0] araddr = 9'h000;
  logic rready = 1'b0;
  logic synth_enable_pin = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  synth_cfg_t synth_cfg;
  exp_t exp_q[$];
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  integer seed;
  logic [6:0] idx_tab [6] = '{IDX_STAMP, IDX_REFOUT, IDX_DIV_ONE, IDX_DIV_TWO, IDX_OSC_BIAS, IDX_SER_EMPH};
  logic [7:0] rst_tab [6] = '{8'h00, 8'h01, 8'h00, 8'h20, 8'h4f, 8'h00};
  logic [2:0] first_tab [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
  logic [2:0] second_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h0};

  always #2.5 clk_sys = ~clk_sys;

  synth_and_stamp_config_regs #(.ADDR_W(9)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn),
    .awvalid(awvalid), .awaddr(awaddr), .awready(awready),
    .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb), .wready(wready),
    .bvalid(bvalid), .bresp(bresp), .bready(bready),
    .arvalid(arvalid), .araddr(araddr), .arready(arready),
    .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready),
    .synth_enable_pin(synth_enable_pin), .synth_cfg(synth_cfg)
  );

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [6:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic done;
    done = 1'b0;
    exp_q.push_back('{1'b0, r, 32'h0000_0000});
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge clk_sys);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [6:0] idx, input logic [31:0] d, input logic [1:0] r);
    logic done;
    done = 1'b0;
    exp_q.push_back('{1'b1, r, d});
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge clk_sys);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Settle time covers the output register and the enable synchroniser
  task automatic settle();
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic check_cfg(input logic [1:0] fc, input logic [1:0] sc, input logic [5:0] t);
    logic [10:0] tot;
    tot = 11'(first_tab[fc]) * 11'(second_tab[sc]) * 11'(t);
    settle();
    cmp(32'(synth_cfg.first_ratio), 32'(first_tab[fc]));
    cmp(32'(synth_cfg.second_ratio), 32'(second_tab[sc]));
    cmp(32'(synth_cfg.third_ratio), 32'(t));
    cmp(32'(synth_cfg.total_ratio), 32'(tot));
  endtask

  task automatic reset_check();
    for (int i = 0; i < 6; i++)
      axi_rd(idx_tab[i], 32'(rst_tab[i]), RESP_OKAY);
    axi_rd(IDX_STATUS, 32'h0000_0003, RESP_OKAY);
    check_cfg(2'd0, 2'd0, 6'd32);
    cmp(32'(synth_cfg.stamp_input_receiver_on), 32'h0000_0000);
    cmp(32'(synth_cfg.stamp_input_pecl_mode), 32'h0000_0000);
    cmp(32'(synth_cfg.ref_clock_output), 32'h0000_0001);
    cmp(32'(synth_cfg.oscillator_bias_level), 32'h0000_004f);
  endtask

  // Result watcher: a handshake is seen here on the half cycle before its taking edge
  always @(negedge clk_sys)
  begin
    exp_t e;
    if ((bvalid && bready) || (rvalid && rready))
    begin
      if (exp_q.size() == 0)
        cmp(32'h0000_0001, 32'h0000_0000);
      else
      begin
        e = exp_q.pop_front();
        if (e.rd)
        begin
          cmp(rdata, e.data);
          cmp(32'(rresp), 32'(e.resp));
        end
        else
          cmp(32'(bresp), 32'(e.resp));
      end
    end
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    logic [7:0] v;
    logic [5:0] t;
    seed = 35757;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    reset_check();
    for (int e = 0; e < 2; e++)
      for (int b = 0; b < 2; b++)
      begin
        synth_enable_pin <= 1'(e);
        axi_wr(IDX_REFOUT, 32'(b), 4'hf, RESP_OKAY);
        settle();
        cmp(32'(synth_cfg.ref_clock_output), 32'(e & b));
      end
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(IDX_STAMP, 32'(i), 4'hf, RESP_OKAY);
      settle();
      cmp(32'(synth_cfg.stamp_input_receiver_on), 32'(i & 1));
      cmp(32'(synth_cfg.stamp_input_pecl_mode), 32'(i >> 1));
    end
    for (int f = 0; f < 4; f++)
      for (int s = 0; s < 4; s++)
      begin
        axi_wr(IDX_DIV_ONE, 32'(s * 4 + f), 4'hf, RESP_OKAY);
        check_cfg(2'(f), 2'(s), 6'd32);
        axi_rd(IDX_STATUS, ((f == 3) || (s == 3)) ? 32'h0000_0007 : 32'h0000_0003, RESP_OKAY);
      end
    axi_wr(IDX_DIV_ONE, 32'h0000_0006, 4'hf, RESP_OKAY);
    for (int k = 0; k < 3; k++)
    begin
      t = (k == 0) ? 6'd1 : (k == 1) ? 6'd63 : 6'(($unsigned($random(seed)) % 63) + 1);
      axi_wr(IDX_DIV_TWO, 32'(t), 4'hf, RESP_OKAY);
      check_cfg(2'd2, 2'd1, t);
    end
    axi_wr(IDX_OSC_BIAS, 32'h0000_004a, 4'hf, RESP_OKAY);
    axi_rd(IDX_OSC_BIAS, 32'h0000_004a, RESP_OKAY);
    settle();
    cmp(32'(synth_cfg.oscillator_bias_level), 32'h0000_004a);
    for (int i = 0; i < 6; i++)
    begin
      v = 8'($random(seed));
      axi_wr(idx_tab[i], {24'h00_0000, v}, 4'hf, RESP_OKAY);
      axi_wr(idx_tab[i], {24'h00_0000, ~v}, 4'h0, RESP_OKAY);
      axi_rd(idx_tab[i], {24'h00_0000, v}, RESP_OKAY);
    end
    settle();
    cmp(32'(synth_cfg.serializer_emphasis_level), 32'(v[3:0]));
    axi_wr(7'h50, 32'h0000_00ff, 4'hf, RESP_SLVERR);
    axi_rd(7'h50, 32'h0000_0000, RESP_SLVERR);
    synth_enable_pin <= 1'b1;
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    reset_check();
    repeat (4) @(posedge clk_sys);
    if (exp_q.size() != 0)
      cmp(32'(exp_q.size()), 32'h0000_0000);
    results();
  end
endmodule // synth_and_stamp_config_regs_tb
